// >>> common/switch_route_pkg.sv
// Package of register numbers, field layouts and link-state types for the switch route block
package switch_route_pkg;

	// Register numbers on the configuration port
	localparam logic [7:0]  REG_DIR_LOW       = 8'h0C;
	localparam logic [7:0]  REG_DIR_HIGH      = 8'h0D;
	localparam logic [7:0]  REG_DEBUG_CFG     = 8'h10;
	localparam logic [7:0]  REG_DEBUG_ORIGIN  = 8'h1F;
	localparam logic [7:0]  REG_EXT_LINK_BASE = 8'h20;
	localparam logic [7:0]  REG_EXT_LINK_LAST = 8'h27;
	localparam logic [7:0]  REG_PROC_LINK_BASE = 8'h40;
	localparam logic [7:0]  REG_PROC_LINK_LAST = 8'h43;

	// Link counts
	localparam int          NUM_EXT_LINKS     = 8;
	localparam int          NUM_PROC_LINKS    = 4;

	// Direction tables
	localparam int          DIR_W             = 4;
	localparam int          DIRS_PER_TABLE    = 8;
	localparam int          NODE_ID_W         = 16;
	localparam logic [31:0] DIR_TABLE_RESET   = 32'h0000_0000;

	// Debug configuration fields
	localparam int          DBG_PULLDOWN_BIT  = 0;
	localparam int          DBG_CALL_EN_BIT   = 1;

	// Debug origin fields
	localparam int          ORIGIN_TILE_BIT   = 0;
	localparam int          ORIGIN_EXT_BIT    = 4;

	// Link register fields
	localparam int          LNK_INBOUND_BIT   = 0;
	localparam int          LNK_OUTBOUND_BIT  = 1;
	localparam int          LNK_JUNK_BIT      = 2;
	localparam int          LNK_NET_LSB       = 4;
	localparam int          LNK_NET_W         = 2;
	localparam int          LNK_DIR_LSB       = 8;
	localparam int          LNK_DEST_LSB      = 16;
	localparam int          LNK_DEST_W        = 8;
	localparam int          LNK_TYPE_LSB      = 24;
	localparam int          LNK_TYPE_W        = 2;

	// Target link type codes
	localparam logic [1:0]  TGT_PROC_LINK     = 2'h0;
	localparam logic [1:0]  TGT_EXT_LINK      = 2'h1;
	localparam logic [1:0]  TGT_CTRL_LINK     = 2'h2;

	// Live route state of one link, driven by the switch fabric
	typedef struct packed {
		logic [LNK_TYPE_W-1:0] target_type;
		logic [LNK_DEST_W-1:0] dest_link;
		logic                  junk;
		logic                  outbound;
		logic                  inbound;
	} link_state_t;

endpackage : switch_route_pkg

// >>> hdl/route_dir_lookup.sv
// Direction lookup from the most significant destination/node mismatch bit
`timescale 1ns/1ps
`default_nettype none
module route_dir_lookup
	import switch_route_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 req,
	input  wire logic [NODE_ID_W-1:0] dest_id,
	input  wire logic [NODE_ID_W-1:0] node_id,
	input  wire logic [31:0]          dir_low,
	input  wire logic [31:0]          dir_high,
	output logic                      valid,
	output logic                      local_hit,
	output logic [DIR_W-1:0]          dir
);

	// Highest set bit of the mismatch vector, scanned low to high so the top one wins
	function automatic logic [3:0] msb_index(input logic [NODE_ID_W-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < NODE_ID_W; i++) begin
			if (v[i]) begin
				idx = i[3:0];
			end
		end
		return idx;
	endfunction : msb_index

	logic [NODE_ID_W-1:0] mismatch;
	logic [3:0]           pos;
	logic [63:0]          table_all;
	logic                 is_local;
	logic [DIR_W-1:0]     dir_sel;

	// Position 15 sits in the top nibble of the high table, position 0 in the bottom of the low one
	assign mismatch  = dest_id ^ node_id;
	assign pos       = msb_index(mismatch);
	assign table_all = {dir_high, dir_low};
	assign dir_sel   = table_all[{pos, 2'b00} +: DIR_W];
	assign is_local  = (mismatch == '0);

	// One cycle from request to answer; the direction is forced to zero on a local hit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid     <= 1'b0;
			local_hit <= 1'b0;
			dir       <= '0;
		end else begin
			valid     <= req;
			local_hit <= req & is_local;
			dir       <= (req && !is_local) ? dir_sel : '0;
		end
	end

endmodule : route_dir_lookup
`default_nettype wire

// >>> hdl/switch_route_debug_status_regs.sv
// Switch routing tables, debug pin control and link route-state registers
`timescale 1ns/1ps
`default_nettype none

module switch_route_debug_status_regs
	import switch_route_pkg::*;
#(
	parameter int N_EXT  = NUM_EXT_LINKS,
	parameter int N_PROC = NUM_PROC_LINKS
) (
	input  wire logic                              REF_CLK,
	input  wire logic                              ARST_N,
	input  wire logic                              CFG_REQ,
	input  wire logic                              CFG_WR,
	input  wire logic [7:0]                        CFG_ADDR,
	input  wire logic [31:0]                       CFG_WDATA,
	output logic                                   CFG_ACK,
	output logic [31:0]                            CFG_RDATA,
	input  wire logic [NODE_ID_W-1:0]              NODE_ID,
	input  wire logic                              RT_REQ,
	input  wire logic [NODE_ID_W-1:0]              RT_DEST_ID,
	output logic                                   RT_VALID,
	output logic                                   RT_LOCAL,
	output logic [DIR_W-1:0]                       RT_DIR,
	input  wire link_state_t [N_EXT-1:0]           EXT_LINK_STATE,
	input  wire link_state_t [N_PROC-1:0]          PROC_LINK_STATE,
	output logic [N_EXT-1:0][DIR_W-1:0]            EXT_LINK_DIR,
	output logic [N_EXT-1:0][LNK_NET_W-1:0]        EXT_LINK_NET,
	output logic [N_PROC-1:0][LNK_NET_W-1:0]       PROC_LINK_NET,
	input  wire logic                              DEBUG_N_IN,
	output logic                                   DEBUG_N_OUT,
	output logic                                   DEBUG_N_OE,
	input  wire logic                              DEBUG_MODE,
	input  wire logic                              TILE_DEBUG_EVT,
	output logic                                   DEBUG_CALL_TRAP
);

	// Address decode helpers, used by both the write and the read path
	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	// Format one link register from live state and its writable fields
	function automatic logic [31:0] pack_link(input link_state_t s, input logic [DIR_W-1:0] d,
			input logic [LNK_NET_W-1:0] n);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[LNK_TYPE_LSB +: LNK_TYPE_W] = s.target_type;
		w[LNK_DEST_LSB +: LNK_DEST_W] = s.dest_link;
		w[LNK_DIR_LSB +: DIR_W]       = d;
		w[LNK_NET_LSB +: LNK_NET_W]   = n;
		w[LNK_JUNK_BIT]               = s.junk;
		w[LNK_OUTBOUND_BIT]           = s.outbound;
		w[LNK_INBOUND_BIT]            = s.inbound;
		return w;
	endfunction : pack_link

	// Configuration registers
	logic [31:0]          dir_low_reg;
	logic [31:0]          dir_high_reg;
	logic                 call_en_reg;
	logic                 pulldown_en_reg;
	logic                 origin_ext_reg;
	logic                 origin_ext_next;
	logic                 origin_tile_reg;
	logic                 origin_tile_next;
	logic [N_EXT-1:0][DIR_W-1:0]      ext_dir_reg;
	logic [N_EXT-1:0][LNK_NET_W-1:0]  ext_net_reg;
	logic [N_PROC-1:0][LNK_NET_W-1:0] proc_net_reg;
	logic                 ack_reg;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;

	// Debug pin synchroniser and edge history
	logic                 dbg_meta_reg;
	logic                 dbg_sync_reg;
	logic                 dbg_prev_reg;
	logic                 trap_reg;
	logic                 oe_reg;

	// Decoded strobes
	logic                 cfg_write;
	logic                 cfg_read;
	logic                 wr_low;
	logic                 wr_high;
	logic                 wr_dbg;
	logic                 wr_origin;
	logic                 hit_ext;
	logic                 hit_proc;
	logic [7:0]           ext_off;
	logic [7:0]           proc_off;
	logic                 dbg_fall;
	logic                 ext_dbg_evt;
	logic [N_EXT-1:0][31:0]  ext_words;
	logic [N_PROC-1:0][31:0] proc_words;

	// Only configuration transactions reach the registers; anything else is unmapped
	assign cfg_write = CFG_REQ & CFG_WR;
	assign cfg_read  = CFG_REQ & ~CFG_WR;
	assign wr_low    = cfg_write && (CFG_ADDR == REG_DIR_LOW);
	assign wr_high   = cfg_write && (CFG_ADDR == REG_DIR_HIGH);
	assign wr_dbg    = cfg_write && (CFG_ADDR == REG_DEBUG_CFG);
	assign wr_origin = cfg_write && (CFG_ADDR == REG_DEBUG_ORIGIN);
	assign hit_ext   = in_range(CFG_ADDR, REG_EXT_LINK_BASE, REG_EXT_LINK_LAST);
	assign hit_proc  = in_range(CFG_ADDR, REG_PROC_LINK_BASE, REG_PROC_LINK_LAST);
	assign ext_off   = CFG_ADDR - REG_EXT_LINK_BASE;
	assign proc_off  = CFG_ADDR - REG_PROC_LINK_BASE;

	// Pin asserted means a high-to-low edge; our own pull-down is ignored only if held three cycles or more, a shorter one self-traps
	assign dbg_fall    = dbg_prev_reg & ~dbg_sync_reg;
	assign ext_dbg_evt = dbg_fall & call_en_reg & ~oe_reg;

	// Hardware events win over a software write in the same cycle
	assign origin_ext_next  = ext_dbg_evt ? 1'b1 :
		TILE_DEBUG_EVT ? 1'b0 :
		wr_origin ? CFG_WDATA[ORIGIN_EXT_BIT] : origin_ext_reg;
	assign origin_tile_next = TILE_DEBUG_EVT ? 1'b1 :
		ext_dbg_evt ? 1'b0 :
		wr_origin ? CFG_WDATA[ORIGIN_TILE_BIT] : origin_tile_reg;

	// Read words of every link register, index order C, D, A, B, G, H, E, F
	genvar gi;
	generate
		for (gi = 0; gi < N_EXT; gi++) begin : g_ext_word
			assign ext_words[gi] = pack_link(EXT_LINK_STATE[gi], ext_dir_reg[gi], ext_net_reg[gi]);
		end
		for (gi = 0; gi < N_PROC; gi++) begin : g_proc_word
			assign proc_words[gi] = pack_link(PROC_LINK_STATE[gi], '0, proc_net_reg[gi]);
		end
	endgenerate

	// Read selection; unmapped numbers read as zero
	assign rdata_next =
		(CFG_ADDR == REG_DIR_LOW)      ? dir_low_reg :
		(CFG_ADDR == REG_DIR_HIGH)     ? dir_high_reg :
		(CFG_ADDR == REG_DEBUG_CFG)    ? {30'h0, call_en_reg, pulldown_en_reg} :
		(CFG_ADDR == REG_DEBUG_ORIGIN) ? {27'h0, origin_ext_reg, 3'h0, origin_tile_reg} :
		hit_ext                        ? ext_words[ext_off[2:0]] :
		hit_proc                       ? proc_words[proc_off[1:0]] : 32'h0000_0000;

	// Direction tables, written whole
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dir_low_reg  <= DIR_TABLE_RESET;
			dir_high_reg <= DIR_TABLE_RESET;
		end else begin
			if (wr_low) begin
				dir_low_reg <= CFG_WDATA;
			end
			if (wr_high) begin
				dir_high_reg <= CFG_WDATA;
			end
		end
	end

	// Debug pin configuration and event origin
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			call_en_reg     <= 1'b0;
			pulldown_en_reg <= 1'b0;
			origin_ext_reg  <= 1'b0;
			origin_tile_reg <= 1'b0;
		end else begin
			if (wr_dbg) begin
				call_en_reg     <= CFG_WDATA[DBG_CALL_EN_BIT];
				pulldown_en_reg <= CFG_WDATA[DBG_PULLDOWN_BIT];
			end
			origin_ext_reg  <= origin_ext_next;
			origin_tile_reg <= origin_tile_next;
		end
	end

	// Writable link fields; route-state bits have no storage, so writes cannot touch them
	generate
		for (gi = 0; gi < N_EXT; gi++) begin : g_ext_reg
			always_ff @(posedge REF_CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					ext_dir_reg[gi] <= '0;
					ext_net_reg[gi] <= '0;
				end else if (cfg_write && hit_ext && (ext_off[2:0] == gi)) begin
					ext_dir_reg[gi] <= CFG_WDATA[LNK_DIR_LSB +: DIR_W];
					ext_net_reg[gi] <= CFG_WDATA[LNK_NET_LSB +: LNK_NET_W];
				end
			end
		end
		for (gi = 0; gi < N_PROC; gi++) begin : g_proc_reg
			always_ff @(posedge REF_CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					proc_net_reg[gi] <= '0;
				end else if (cfg_write && hit_proc && (proc_off[1:0] == gi)) begin
					proc_net_reg[gi] <= CFG_WDATA[LNK_NET_LSB +: LNK_NET_W];
				end
			end
		end
	endgenerate

	// Configuration answer one cycle after every request, read or write
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= CFG_REQ;
			rdata_reg <= cfg_read ? rdata_next : 32'h0000_0000;
		end
	end

	// Pin is idle high, so the synchroniser resets high to avoid a false edge after reset
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dbg_meta_reg <= 1'b1;
			dbg_sync_reg <= 1'b1;
			dbg_prev_reg <= 1'b1;
			trap_reg     <= 1'b0;
			oe_reg       <= 1'b0;
		end else begin
			dbg_meta_reg <= DEBUG_N_IN;
			dbg_sync_reg <= dbg_meta_reg;
			dbg_prev_reg <= dbg_sync_reg;
			trap_reg     <= ext_dbg_evt;
			oe_reg       <= pulldown_en_reg & DEBUG_MODE;
		end
	end

	// Route lookup against this node's identifier
	route_dir_lookup u_lookup (
		.clk       (REF_CLK),
		.rst_n     (ARST_N),
		.req       (RT_REQ),
		.dest_id   (RT_DEST_ID),
		.node_id   (NODE_ID),
		.dir_low   (dir_low_reg),
		.dir_high  (dir_high_reg),
		.valid     (RT_VALID),
		.local_hit (RT_LOCAL),
		.dir       (RT_DIR)
	);

	// Outputs
	assign CFG_ACK         = ack_reg;
	assign CFG_RDATA       = rdata_reg;
	assign EXT_LINK_DIR    = ext_dir_reg;
	assign EXT_LINK_NET    = ext_net_reg;
	assign PROC_LINK_NET   = proc_net_reg;
	assign DEBUG_N_OUT     = 1'b0;                              // Open drain: only ever pulls low
	assign DEBUG_N_OE      = oe_reg;
	assign DEBUG_CALL_TRAP = trap_reg;

	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);

	sequence write_to(logic [7:0] a);
		CFG_REQ && CFG_WR && (CFG_ADDR == a);
	endsequence

	sequence read_of(logic [7:0] a);
		CFG_REQ && !CFG_WR && (CFG_ADDR == a);
	endsequence

	sequence pin_falls_enabled;
		call_en_reg && !oe_reg && dbg_prev_reg && !dbg_sync_reg;
	endsequence

	cfg_ack_timing_a: assert property (CFG_REQ |=> CFG_ACK ##0 $past(CFG_REQ) == CFG_ACK)
		else $error("configuration answer not one cycle after request");
	cfg_ack_cause_a: assert property (CFG_ACK |-> $past(CFG_REQ))
		else $error("answer without a request");
	dir_low_write_a: assert property (write_to(REG_DIR_LOW) ##1 !CFG_REQ ##1 read_of(REG_DIR_LOW) |=>
		CFG_RDATA == $past(CFG_WDATA, 3))
		else $error("low direction table readback wrong");
	ext_dir_write_a: assert property (write_to(REG_EXT_LINK_BASE) |=>
		EXT_LINK_DIR[0] == $past(CFG_WDATA[LNK_DIR_LSB +: DIR_W]))
		else $error("link direction field not written");
	ext_state_read_a: assert property (read_of(REG_EXT_LINK_BASE) |=>
		CFG_RDATA[LNK_INBOUND_BIT] == $past(EXT_LINK_STATE[0].inbound) &&
		CFG_RDATA[LNK_JUNK_BIT] == $past(EXT_LINK_STATE[0].junk))
		else $error("link route state not reported");
	proc_dir_zero_a: assert property (read_of(REG_PROC_LINK_BASE) |=>
		CFG_RDATA[LNK_DIR_LSB +: DIR_W] == '0)
		else $error("processor link shows a direction field");
	local_route_a: assert property (RT_REQ && (RT_DEST_ID == NODE_ID) |=> RT_VALID && RT_LOCAL)
		else $error("matching destination not delivered locally");
	top_bit_route_a: assert property (RT_REQ && (RT_DEST_ID[15] != NODE_ID[15]) |=>
		RT_VALID && !RT_LOCAL && RT_DIR == $past(dir_high_reg[31:28]))
		else $error("top mismatch bit not routed from top entry");
	bit0_route_a: assert property (RT_REQ && ((RT_DEST_ID ^ NODE_ID) == 16'h0001) |=>
		RT_DIR == $past(dir_low_reg[3:0]))
		else $error("bit 0 mismatch not routed from bottom entry");
	trap_raise_a: assert property (pin_falls_enabled |=> DEBUG_CALL_TRAP)
		else $error("debug call trap not raised");
	trap_gate_a: assert property (!call_en_reg |=> !DEBUG_CALL_TRAP)
		else $error("trap raised while disabled");
	pin_pull_down_a: assert property (pulldown_en_reg && DEBUG_MODE |=> DEBUG_N_OE && !DEBUG_N_OUT)
		else $error("debug pin not pulled low in debug mode");
	origin_ext_a: assert property (pin_falls_enabled ##0 !TILE_DEBUG_EVT |=>
		origin_ext_reg && !origin_tile_reg)
		else $error("pin origin not recorded");
	origin_tile_a: assert property (TILE_DEBUG_EVT && !ext_dbg_evt |=> origin_tile_reg && !origin_ext_reg)
		else $error("tile origin not recorded");
	origin_win_a: assert property (write_to(REG_DEBUG_ORIGIN) ##0 TILE_DEBUG_EVT |=> origin_tile_reg)
		else $error("software write beat the tile event");

endmodule : switch_route_debug_status_regs
`default_nettype wire

// >>> verification/far_side_model.sv
// Far-side model: live route state of every link and the pulled-up debug wire
`timescale 1ns/1ps
`default_nettype none
module far_side_model
	import switch_route_pkg::*;
(
	input  wire logic [7:0]                   pattern,
	input  wire logic                         ext_pull,
	input  wire logic                         dut_out,
	input  wire logic                         dut_oe,
	output link_state_t [NUM_EXT_LINKS-1:0]   ext_state,
	output link_state_t [NUM_PROC_LINKS-1:0]  proc_state,
	output logic                              debug_n
);
	// One link state per pattern byte; only the three legal target codes are ever shown
	function automatic link_state_t state_of(input logic [7:0] k);
		state_of = '{target_type: 2'(k % 8'h03), dest_link: k, junk: k[2], outbound: k[1], inbound: k[0]};
	endfunction : state_of

	// Every link differs, so a swapped register order reads back the wrong word
	always_comb begin
		for (int i = 0; i < NUM_EXT_LINKS; i++) begin
			ext_state[i] = state_of(pattern + 8'(i * 37));
		end
		for (int i = 0; i < NUM_PROC_LINKS; i++) begin
			proc_state[i] = state_of(pattern ^ 8'(i * 91 + 5));
		end
	end

	// Open-drain wire with pull-up: low when the debugger or the node pulls it
	assign debug_n = ~((dut_oe & ~dut_out) | ext_pull);
endmodule : far_side_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the route tables, debug pin control and link state registers
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import switch_route_pkg::*;
;
	logic                                 clk = 1'b0;
	logic                                 arst_n = 1'b0;
	logic                                 cfg_req = 1'b0;
	logic                                 cfg_wr = 1'b0;
	logic [7:0]                           cfg_addr = 8'h00;
	logic [31:0]                          cfg_wdata = 32'h0;
	logic                                 rt_req = 1'b0;
	logic [15:0]                          dest_id = 16'h0;
	logic [15:0]                          node_id = 16'hA5C3;
	logic                                 dbg_mode = 1'b0;
	logic                                 tile_evt = 1'b0;
	logic                                 ext_pull = 1'b0;
	logic [7:0]                           pattern = 8'h3C;
	logic [31:0]                          rd;
	logic                                 cfg_ack, rt_valid, rt_local, dbg_n, dbg_out, dbg_oe, trap;
	logic [31:0]                          cfg_rdata;
	logic [3:0]                           rt_dir;
	link_state_t [NUM_EXT_LINKS-1:0]      ext_st;
	link_state_t [NUM_PROC_LINKS-1:0]     proc_st;
	logic [NUM_EXT_LINKS-1:0][3:0]        ext_dir;
	logic [NUM_EXT_LINKS-1:0][1:0]        ext_net;
	logic [NUM_PROC_LINKS-1:0][1:0]       proc_net;
	int                                   err_total = 0;
	int                                   cmp_count = 0;
	int                                   cycles = 0;

	switch_route_debug_status_regs DUT (.REF_CLK(clk), .ARST_N(arst_n), .CFG_REQ(cfg_req), .CFG_WR(cfg_wr),
		.CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .CFG_ACK(cfg_ack), .CFG_RDATA(cfg_rdata), .NODE_ID(node_id),
		.RT_REQ(rt_req), .RT_DEST_ID(dest_id), .RT_VALID(rt_valid), .RT_LOCAL(rt_local), .RT_DIR(rt_dir),
		.EXT_LINK_STATE(ext_st), .PROC_LINK_STATE(proc_st), .EXT_LINK_DIR(ext_dir), .EXT_LINK_NET(ext_net),
		.PROC_LINK_NET(proc_net), .DEBUG_N_IN(dbg_n), .DEBUG_N_OUT(dbg_out), .DEBUG_N_OE(dbg_oe),
		.DEBUG_MODE(dbg_mode), .TILE_DEBUG_EVT(tile_evt), .DEBUG_CALL_TRAP(trap));
	far_side_model partner (.pattern(pattern), .ext_pull(ext_pull), .dut_out(dbg_out),
		.dut_oe(dbg_oe), .ext_state(ext_st), .proc_state(proc_st), .debug_n(dbg_n));

	// Free-running clock, 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One configuration access; request is a one-cycle pulse, answer is looked at in the ack cycle
	task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cfg_req <= 1'b1;
		cfg_wr <= wr;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_req <= 1'b0;
		#1;
		chk(32'(cfg_ack), 32'h1);
		rd = cfg_rdata;
	endtask : cfg

	task automatic route(input logic [15:0] d, input logic [3:0] e_dir, input logic e_loc);
		@(posedge clk);
		rt_req <= 1'b1;
		dest_id <= d;
		@(posedge clk);
		rt_req <= 1'b0;
		#1;
		chk(32'(rt_valid), 32'h1);
		chk(32'({rt_local, rt_dir}), 32'({e_loc, e_dir}));
	endtask : route

	function automatic logic [31:0] word(input link_state_t s, input logic [3:0] d, input logic [1:0] n);
		word = {6'h0, s.target_type, s.dest_link, 4'h0, d, 2'h0, n, 1'b0, s.junk, s.outbound, s.inbound};
	endfunction : word

	// Writable configuration comes up cleared; unmapped numbers read zero but are still acknowledged
	task automatic t_reset;
		logic [7:0] addrs [6] = '{8'h0C, 8'h0D, 8'h10, 8'h1F, 8'h11, 8'h44};
		foreach (addrs[i]) begin
			cfg(1'b0, addrs[i], 32'h0);
			chk(rd, 32'h0);
		end
	endtask : t_reset

	// Each mismatch position 0..15 selects its own nibble; lower bits also differ to catch a wrong priority
	task automatic t_tables;
		cfg(1'b1, REG_DIR_LOW, 32'h7654_3210);
		cfg(1'b0, REG_DIR_LOW, 32'h0);
		chk(rd, 32'h7654_3210);
		cfg(1'b1, REG_DIR_HIGH, 32'hFEDC_BA98);
		cfg(1'b0, REG_DIR_HIGH, 32'h0);
		chk(rd, 32'hFEDC_BA98);
		for (int b = 0; b < 16; b++) begin
			route(node_id ^ 16'((32'h1 << (b + 1)) - 1), 4'(b), 1'b0);
		end
		route(node_id, 4'h0, 1'b1);
	endtask : t_tables

	// All-ones writes must only reach direction and network; route state stays live
	task automatic t_links;
		for (int i = 0; i < NUM_EXT_LINKS; i++) begin
			cfg(1'b1, REG_EXT_LINK_BASE + 8'(i), 32'hFFFF_FFFF);
			cfg(1'b0, REG_EXT_LINK_BASE + 8'(i), 32'h0);
			chk(rd, word(ext_st[i], 4'hF, 2'h3));
			chk(32'({ext_dir[i], ext_net[i]}), 32'h3F);
		end
		for (int i = 0; i < NUM_PROC_LINKS; i++) begin
			cfg(1'b1, REG_PROC_LINK_BASE + 8'(i), 32'hFFFF_FFFF);
			cfg(1'b0, REG_PROC_LINK_BASE + 8'(i), 32'h0);
			chk(rd, word(proc_st[i], 4'h0, 2'h3));
			chk(32'(proc_net[i]), 32'h3);
		end
		pattern <= 8'hC3;
		cfg(1'b1, REG_EXT_LINK_BASE + 8'h02, 32'h0);
		cfg(1'b0, REG_EXT_LINK_BASE + 8'h02, 32'h0);
		chk(rd, word(ext_st[2], 4'h0, 2'h0));
	endtask : t_links

	// Debugger, or our own debug mode, pulls the wire for nine cycles; traps seen in the first eight are counted
	task automatic pin_pulse(input logic by_mode, input int exp);
		int n;
		n = 0;
		@(posedge clk);
		if (by_mode) begin
			dbg_mode <= 1'b1;
		end else begin
			ext_pull <= 1'b1;
		end
		repeat (8) begin
			@(posedge clk);
			#1;
			n += int'(trap === 1'b1);
		end
		@(posedge clk);
		ext_pull <= 1'b0;
		dbg_mode <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(n), 32'(exp));
	endtask : pin_pulse

	task automatic t_debug;
		cfg(1'b1, REG_DEBUG_CFG, 32'h2);
		pin_pulse(1'b0, 1);
		cfg(1'b0, REG_DEBUG_ORIGIN, 32'h0);
		chk(rd, 32'h10);
		@(posedge clk);
		tile_evt <= 1'b1;
		@(posedge clk);
		tile_evt <= 1'b0;
		cfg(1'b0, REG_DEBUG_ORIGIN, 32'h0);
		chk(rd, 32'h01);
		// Software may rewrite the origin, but a tile event in the same cycle wins
		cfg(1'b1, REG_DEBUG_ORIGIN, 32'h10);
		cfg(1'b0, REG_DEBUG_ORIGIN, 32'h0);
		chk(rd, 32'h10);
		fork
			cfg(1'b1, REG_DEBUG_ORIGIN, 32'h0);
			begin
				@(posedge clk);
				tile_evt <= 1'b1;
				@(posedge clk);
				tile_evt <= 1'b0;
			end
		join
		cfg(1'b0, REG_DEBUG_ORIGIN, 32'h0);
		chk(rd, 32'h01);
		cfg(1'b1, REG_DEBUG_CFG, 32'h1);
		pin_pulse(1'b0, 0);
		cfg(1'b0, REG_DEBUG_ORIGIN, 32'h0);
		chk(rd, 32'h01);
		@(posedge clk);
		dbg_mode <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(32'({dbg_oe, dbg_n}), 32'h2);
		@(posedge clk);
		dbg_mode <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(32'({dbg_oe, dbg_n}), 32'h1);
		// Our own pull-down must not trap us even with the call enabled
		cfg(1'b1, REG_DEBUG_CFG, 32'h3);
		pin_pulse(1'b1, 0);
		cfg(1'b0, REG_DEBUG_ORIGIN, 32'h0);
		chk(rd, 32'h01);
	endtask : t_debug

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// Reset for three cycles, then run every scenario in turn
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_tables();
		t_links();
		t_debug();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
